// *** hw/sdpf_framer.v ***
/*
  serial data packing framer of one port: collects received serial bytes,
  flushes them as one packet on length, delimiter, idle timeout or full
  buffer, delivers to connected hosts, and handles modem control requests.
  assumes rx bytes, host handshakes and settings are synchronous to
  core_clk and that settings stay stable while a packet is collected.
*/
`timescale 1ns/1ps
`include "sdpf_map.vh"

// Notes on behaviour
// R01: flush when count equals nonzero packet length
// R02: zero packet length disables length flush
// R03: delimiter one match starts a flush
// R04: enabled delimiter two also ends packet
// R05: configurer must enable delimiter one first
// R06: 1 Kbyte buffer, full buffer always flushes
// R07: plus-one/plus-two waits for extra bytes
// R08: strip mode drops the delimiter byte
// R09: do-nothing sends delimiter, is reset choice
// R10: zero force-transmit timeout disables timeout flush
// R11: nonzero timeout flushes when interval reaches it
// R12: configurer picks timeout above 10 ms
// R13: sender keeps gaps and length in bounds
// R14: link down with low setting drops RTS/DTR
// R15: multi-connection uses local serial parameters
// R16: ignore-jammed skips stuck hosts, else wait
// R17: multi-connection drops commands unless allowed
// R18: newest control command wins
// R19: idle timer restarts per byte and flush
// R20: coincident triggers give one flush, empty buffer
module sdpf_framer #(
  parameter NH        = 8,                  // host slots
  parameter CFG_W     = 16,                 // serial parameter word width
  parameter MS_CYCLES = `SDPF_MS_CYCLES     // cycles per millisecond tick
) (
  input  wire             core_clk,         // 25 MHz system clock
  input  wire             rst_n,            // async reset, active low
  input  wire             rx_valid,         // received serial byte strobe
  input  wire [7:0]       rx_data,          // received serial byte
  output wire             rx_ready,         // framer takes bytes
  input  wire [10:0]      pkt_len,          // packet length, 0 = off
  input  wire [7:0]       delim1,           // first delimiter value
  input  wire             delim1_en,        // first delimiter enable
  input  wire [7:0]       delim2,           // second delimiter value
  input  wire             delim2_en,        // second delimiter enable
  input  wire [1:0]       delim_proc,       // delimiter processing mode
  input  wire [15:0]      force_ms,         // idle timeout in ms, 0 = off
  input  wire [3:0]       max_conn,         // allowed connections 1..8
  input  wire             ignore_jammed,    // skip stuck hosts
  input  wire             allow_drv_ctrl,   // accept host commands
  input  wire             conn_down_low,    // drop RTS/DTR on link loss
  input  wire             net_up,           // network connection alive
  input  wire [NH-1:0]    host_active,      // host slot connected
  input  wire [NH-1:0]    host_ready,       // host slot can take a byte
  output wire [NH-1:0]    host_take,        // byte handed to host slot
  output wire             tx_valid,         // packet byte on offer
  output reg  [7:0]       tx_data,          // packet byte
  output reg              tx_last,          // final byte of packet
  input  wire             cmd_valid,        // control command strobe
  input  wire             cmd_rts,          // commanded RTS level
  input  wire             cmd_dtr,          // commanded DTR level
  input  wire [CFG_W-1:0] host_cfg,         // host-requested parameters
  input  wire [CFG_W-1:0] local_cfg,        // locally set parameters
  output reg  [CFG_W-1:0] ser_cfg,          // parameters in use
  output reg              rts_out,          // RTS pin level
  output reg              dtr_out,          // DTR pin level
  output reg              flush_pulse       // one pulse per flush
);

  localparam ST_COLL = 2'h0;                // collecting bytes
  localparam ST_LOAD = 2'h1;                // fetching next byte
  localparam ST_SEND = 2'h2;                // byte on offer
  localparam [10:0] DEPTH_C = `SDPF_FULL_CNT; // buffer size as count
  localparam integer TICK_I = MS_CYCLES - 1;  // prescaler top, full width
  localparam [14:0] TICK_MAX = TICK_I[14:0];  // cut on purpose, 1 ms fits

  reg  [1:0]          state;                // framer state
  reg  [1:0]          next_state;           // framer next state
  reg  [10:0]         fill;                 // bytes in buffer
  reg  [`SDPF_AW-1:0] rd_idx;               // drain index
  reg  [1:0]          post;                 // bytes still owed after delim
  reg  [14:0]         tick_cnt;             // millisecond prescaler
  reg  [15:0]         idle_ms;              // ms since last byte
  reg                 rts_req;              // commanded RTS
  reg                 dtr_req;              // commanded DTR
  wire [7:0]          rd_byte;              // store read data

  // matches trip the given byte value
  function dmatch;
    input [7:0] b;
    input [7:0] v;
    input       en;
    begin
      dmatch = en & (b == v);
    end
  endfunction

  wire accept   = rx_valid & (state == ST_COLL);
  wire multi    = (max_conn >= `SDPF_MULTI_MIN);
  // second delimiter only counts while the first one is enabled
  wire m1       = dmatch(rx_data, delim1, delim1_en);              // R03
  wire m2       = dmatch(rx_data, delim2, delim1_en & delim2_en);  // R04 R05
  wire hit_dlm  = (m1 | m2) & (post == 2'h0);
  wire strip    = (delim_proc == `SDPF_PROC_STRIP);
  wire store_en = accept & ~(hit_dlm & strip);                     // R08
  wire [10:0] fill_after = fill + {10'h000, store_en};

  // flush triggers seen on the byte being taken
  wire len_hit  = store_en & (pkt_len != 11'h000) & (fill_after == pkt_len); // R01 R02
  wire full_hit = store_en & (fill_after == DEPTH_C);                         // R06
  wire dlm_now  = accept & hit_dlm &
                  ((delim_proc == `SDPF_PROC_NONE) | strip);                  // R09 R08
  wire post_hit = accept & (post == 2'h1);                                    // R07
  // idle timeout only while nothing arrives this cycle
  wire tmo_hit  = (state == ST_COLL) & ~accept & (force_ms != 16'h0000) &
                  (fill != 11'h000) & (idle_ms >= force_ms);                  // R10 R11
  // all triggers merge into one flush, empty packets are not sent
  wire flush_go = ((len_hit | full_hit | dlm_now | post_hit) & (fill_after != 11'h000)) |
                  tmo_hit;                                                    // R20

  // delivery: all live hosts, or any live host when jams are skipped
  wire any_live = |host_active;
  wire all_ok   = &(host_ready | ~host_active);
  wire some_ok  = |(host_ready & host_active) | ~any_live;
  wire deliver  = (multi & ignore_jammed) ? some_ok : all_ok;             // R16
  wire tx_take  = tx_valid & deliver;

  assign rx_ready  = (state == ST_COLL);
  assign tx_valid  = (state == ST_SEND);
  assign host_take = {NH{tx_take}} & host_active & host_ready;            // R16

  sdpf_store #(
    .DW    (8),
    .DEPTH (`SDPF_DEPTH),
    .AW    (`SDPF_AW)
  ) u_store (
    .core_clk (core_clk),
    .wr_en    (store_en),
    .wr_idx   (fill[`SDPF_AW-1:0]),
    .wr_data  (rx_data),
    .rd_idx   (rd_idx),
    .rd_data  (rd_byte)
  );

  // state choice; a flush always drains the whole buffer
  always @* begin
    next_state = state;
    case (state)
      ST_COLL: begin
        if (flush_go) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_state = ST_SEND;
      end
      ST_SEND: begin
        if (tx_take) begin
          next_state = tx_last ? ST_COLL : ST_LOAD;
        end
      end
      default: begin
        next_state = ST_COLL;
      end
    endcase
  end

  // fill count, drain index, delimiter tail and output byte
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_COLL;
      fill        <= 11'h000;
      rd_idx      <= 10'h000;
      post        <= 2'h0;
      tx_data     <= 8'h00;
      tx_last     <= 1'b0;
      flush_pulse <= 1'b0;
    end else begin
      state       <= next_state;
      flush_pulse <= (state == ST_COLL) & flush_go;
      case (state)
        ST_COLL: begin
          fill   <= fill_after;
          rd_idx <= 10'h000;
          if (flush_go) begin
            post <= 2'h0;                                     // R20
          end else if (accept & hit_dlm & (delim_proc == `SDPF_PROC_PLUS1)) begin
            post <= 2'h1;                                     // R07
          end else if (accept & hit_dlm & (delim_proc == `SDPF_PROC_PLUS2)) begin
            post <= 2'h2;                                     // R07
          end else if (accept & (post != 2'h0)) begin
            post <= post - 2'h1;                              // R07
          end
        end
        ST_LOAD: begin
          // registered so the byte leaves from a flip-flop
          tx_data <= rd_byte;
          tx_last <= ({1'b0, rd_idx} == fill - 11'h001);
        end
        ST_SEND: begin
          if (tx_take) begin
            if (tx_last) begin
              fill    <= 11'h000;                             // R20
              tx_last <= 1'b0;
            end else begin
              rd_idx <= rd_idx + 10'h001;
            end
          end
        end
        default: begin
          fill <= 11'h000;
        end
      endcase
    end
  end

  // idle timer: restarts on each byte and on flush, saturates at the top
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 15'h0000;
      idle_ms  <= 16'h0000;
    end else if (accept | flush_go | (state != ST_COLL)) begin
      tick_cnt <= 15'h0000;                                   // R19
      idle_ms  <= 16'h0000;                                   // R19
    end else if (tick_cnt == TICK_MAX) begin
      tick_cnt <= 15'h0000;
      if (idle_ms != 16'hFFFF) begin
        idle_ms <= idle_ms + 16'h0001;                        // R11
      end
    end else begin
      tick_cnt <= tick_cnt + 15'h0001;
    end
  end

  // host control: filtered in multi mode, last one received stays
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_req <= `SDPF_RTS_RST;
      dtr_req <= `SDPF_DTR_RST;
    end else if (cmd_valid & (~multi | allow_drv_ctrl)) begin // R17
      rts_req <= cmd_rts;                                     // R18
      dtr_req <= cmd_dtr;                                     // R18
    end
  end

  // pins and serial parameters; the link forces lines only when asked
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_out <= `SDPF_RTS_RST;
      dtr_out <= `SDPF_DTR_RST;
      ser_cfg <= {CFG_W{1'b0}};
    end else begin
      rts_out <= rts_req & ~(conn_down_low & ~net_up);        // R14
      dtr_out <= dtr_req & ~(conn_down_low & ~net_up);        // R14
      ser_cfg <= multi ? local_cfg : host_cfg;                // R15
    end
  end

endmodule // sdpf_framer

// *** hw/sdpf_map.vh ***
/*
  constants of the serial data packing framer: buffer size, delimiter
  processing codes, reset values and the millisecond tick.
  assumes it is included by bare name from the framer design files.
*/
`ifndef SDPF_MAP_VH
`define SDPF_MAP_VH

// receive buffer geometry, one per serial port
`define SDPF_DEPTH        1024
`define SDPF_AW           10
`define SDPF_FULL_CNT     11'h400
`define SDPF_CW           11

// delimiter processing selector codes
`define SDPF_PROC_NONE    2'h0
`define SDPF_PROC_PLUS1   2'h1
`define SDPF_PROC_PLUS2   2'h2
`define SDPF_PROC_STRIP   2'h3

// multi-connection threshold on the connection count
`define SDPF_MULTI_MIN    4'h2

// reset levels of the modem-control requests
`define SDPF_RTS_RST      1'b1
`define SDPF_DTR_RST      1'b1

// timer base: one millisecond in core clock cycles
`define SDPF_TICK_MS      1
`define SDPF_CLK_KHZ      25000
`define SDPF_MS_CYCLES    (`SDPF_TICK_MS * `SDPF_CLK_KHZ)

`endif

// *** hw/sdpf_store.v ***
/*
  byte store of the framer: flip-flop array with one write and one
  asynchronous indexed read port.
  assumes the caller keeps indices below the depth and owns all pointers.
*/
`timescale 1ns/1ps

module sdpf_store #(
  parameter DW    = 8,                 // byte width
  parameter DEPTH = 1024,              // entries
  parameter AW    = 10                 // index width
) (
  input  wire          core_clk,       // system clock
  input  wire          wr_en,          // write strobe
  input  wire [AW-1:0] wr_idx,         // write index
  input  wire [DW-1:0] wr_data,        // byte written
  input  wire [AW-1:0] rd_idx,         // read index
  output wire [DW-1:0] rd_data         // byte at read index
);

  reg [DW-1:0] mem [0:DEPTH-1];        // storage, no reset needed

  // plain write, contents are only meaningful below the fill count
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // read is a mux; the framer registers it before it leaves the block
  assign rd_data = mem[rd_idx];

endmodule // sdpf_store

// *** verification/sdpf_framer_properties.sv ***
/*
  port checker of the framer: flush, delivery and modem control.
  assumes a bind onto sdpf_framer, one clock domain.
*/
`timescale 1ns/1ps
module sdpf_props #(
  parameter NH    = 8,
  parameter CFG_W = 16
) (
  input logic             core_clk,
  input logic             rst_n,
  input logic             rx_valid,
  input logic [7:0]       rx_data,
  input logic             rx_ready,
  input logic [10:0]      pkt_len,
  input logic [7:0]       delim1,
  input logic             delim1_en,
  input logic [1:0]       delim_proc,
  input logic [3:0]       max_conn,
  input logic             ignore_jammed,
  input logic             allow_drv_ctrl,
  input logic             conn_down_low,
  input logic             net_up,
  input logic [NH-1:0]    host_active,
  input logic [NH-1:0]    host_ready,
  input logic [NH-1:0]    host_take,
  input logic             tx_valid,
  input logic             cmd_valid,
  input logic             cmd_rts,
  input logic [CFG_W-1:0] host_cfg,
  input logic [CFG_W-1:0] local_cfg,
  input logic [CFG_W-1:0] ser_cfg,
  input logic             rts_out,
  input logic             dtr_out,
  input logic             flush_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire tk = rx_valid && rx_ready; // byte taken this edge
  property p_len; tk && pkt_len == 11'h001 && !(delim1_en && delim_proc == 2'h3) |=> flush_pulse; endproperty
  a_len: assert property (p_len) else $error("no flush on length");
  property p_dlm; tk && delim1_en && rx_data == delim1 && delim_proc == 2'h0 |=> flush_pulse; endproperty
  a_dlm: assert property (p_dlm) else $error("no flush on delimiter");
  property p_one; flush_pulse |=> !flush_pulse && !rx_ready; endproperty
  a_one: assert property (p_one) else $error("flush repeated");
  // accepted commands land two edges later
  property p_cmd; cmd_valid && (max_conn < 4'h2 || allow_drv_ctrl) && !conn_down_low |-> ##2 rts_out == $past(cmd_rts, 2);
  endproperty
  a_cmd: assert property (p_cmd) else $error("rts not from newest command");
  property p_down; conn_down_low && !net_up |=> !rts_out && !dtr_out; endproperty
  a_down: assert property (p_down) else $error("modem lines not low on link loss");
  property p_cfg; 1'b1 |=> ser_cfg == $past(max_conn >= 4'h2 ? local_cfg : host_cfg); endproperty
  a_cfg: assert property (p_cfg) else $error("wrong serial parameters");
  property p_take; host_take != '0 |-> tx_valid && (host_take & ~(host_active & host_ready)) == '0; endproperty
  a_take: assert property (p_take) else $error("byte to idle host");
  property p_wait; tx_valid && !(ignore_jammed && max_conn >= 4'h2) && (host_active & ~host_ready) != '0 |-> host_take == '0;
  endproperty
  a_wait: assert property (p_wait) else $error("jammed host skipped");
  c_strip: cover property (flush_pulse && delim_proc == 2'h3);
  c_skip: cover property (host_take != '0 && ignore_jammed);
  c_cmd: cover property (cmd_valid && allow_drv_ctrl);
endmodule // sdpf_props
bind sdpf_framer sdpf_props #(.NH(NH), .CFG_W(CFG_W)) sdpf_props_i (.*);

// *** verification/sdpf_serial_dev.sv ***
/*
  serial device model feeding the framer.
  assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ps
module sdpf_serial_dev (
  input  logic       core_clk, // system clock
  input  logic       rx_ready, // framer takes bytes
  output logic       rx_valid, // byte present
  output logic [7:0] rx_data   // byte lines
);
  initial rx_valid = 1'b0;
  initial rx_data = 8'h00;
  // hold the byte until an edge takes it, no gap longer than the timeout
  task put(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data  <= b;
    do @(posedge core_clk); while (!rx_ready);
  endtask
  // released lines must not keep the stale byte
  task idle;
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
endmodule // sdpf_serial_dev

// *** verification/sdpf_framer_tb.sv ***
/*
  self-checking bench of the framer driven by the serial device model.
  assumes the framer, its header and the checker are compiled first.
*/
`timescale 1ns/1ps
module sdpf_framer_tb;
  logic        core_clk, rx_valid, rx_ready, tx_valid, tx_last, flush_pulse, rts_out, dtr_out;
  logic        rst_n = 0, delim1_en = 0, delim2_en = 0, ignore_jammed = 0, allow_drv_ctrl = 0;
  logic        conn_down_low = 0, net_up = 1, cmd_valid = 0, cmd_rts = 1, cmd_dtr = 1;
  logic [7:0]  rx_data, tx_data, host_take, delim1 = 8'h0d, delim2 = 8'h0a;
  logic [7:0]  host_active = 8'h03, host_ready = 8'h00;
  logic [10:0] pkt_len = 11'h000;
  logic [1:0]  delim_proc = 2'h0;
  logic [3:0]  max_conn = 4'h1;
  logic [15:0] force_ms = 16'h0000, host_cfg = 16'h1234, local_cfg = 16'h5678, ser_cfg;
  logic [8:0]  q[$];           // expected {last, byte}
  int          num_errors = 0; // mismatches
  int          num_checks = 0; // comparisons
  int          i, k, p;
  sdpf_framer #(.MS_CYCLES(4)) sdpf_framer_i (.*); // short ms tick keeps timeouts brief
  sdpf_serial_dev sdpf_serial_dev_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task chk_byte(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task chk_lvl(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t level %h exp %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // note the expected byte, then offer it
  task pk(input logic [7:0] b, input logic keep, input logic last);
    if (keep) q.push_back({last, b});
    sdpf_serial_dev_i.put(b);
  endtask
  // bounded wait until every noted byte went out
  task drain;
    sdpf_serial_dev_i.idle();
    for (k = 0; k < 40000 && (q.size() != 0 || !rx_ready); k++) @(posedge core_clk);
    if (k == 40000) chk_lvl(16'h0bad, 16'h0000);
    $display("test done at %0t", $time);
  endtask
  // two commands back to back, then the pins
  task cmd(input logic r1, input logic d1, input logic r2, input logic d2, input logic [1:0] exp);
    cmd_valid <= 1'b1;
    cmd_rts   <= r1;
    cmd_dtr   <= d1;
    @(posedge core_clk);
    cmd_rts   <= r2;
    cmd_dtr   <= d2;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk_lvl({14'h0, rts_out, dtr_out}, {14'h0, exp});
    $display("test done at %0t", $time);
  endtask
  // host readiness wanders so waits and skips both happen
  always @(posedge core_clk) host_ready <= 8'($urandom);
  // each byte handed on is matched against the oldest note
  always @(posedge core_clk) if (rst_n && tx_valid && host_take != 8'h00)
    chk_byte({tx_last, tx_data}, q.size() ? q.pop_front() : 9'h1ff);
  initial begin
    repeat (60000) @(posedge core_clk);
    chk_lvl(16'h0dea, 16'h0000);
    give_verdict;
  end
  initial begin
    void'($urandom(32'had97));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk_lvl({rts_out, dtr_out, ser_cfg[13:0]}, {2'b11, 14'h0000});
    @(posedge core_clk);
    chk_lvl(ser_cfg, host_cfg);
    pkt_len <= 11'h001;
    for (i = 0; i < 3; i++) pk(8'($urandom), 1, 1);
    drain;
    pkt_len <= 11'h000;
    delim1_en <= 1'b1;
    for (p = 0; p < 4; p++) begin
      delim_proc <= 2'(p);
      pk(8'h41, 1, p == 3);
      pk(8'h0d, p != 3, p == 0);
      if (p == 1 || p == 2) pk(8'h42, 1, p == 1);
      if (p == 2) pk(8'h43, 1, 1);
      drain;
    end
    delim_proc <= 2'h0;
    delim2_en <= 1'b1;
    pk(8'h41, 1, 0);
    pk(8'h0a, 1, 1);
    drain;
    delim1_en <= 1'b0;
    delim2_en <= 1'b0;
    force_ms <= 16'h000b;
    pk(8'h51, 1, 0);
    for (i = 0; i < 2; i++) begin
      sdpf_serial_dev_i.idle();
      repeat (30) @(posedge core_clk);
      pk(8'h52 + 8'(i), 1, i == 1);
    end
    drain;
    force_ms <= 16'h0000;
    pk(8'h61, 1, 0);
    sdpf_serial_dev_i.idle();
    repeat (60) @(posedge core_clk);
    chk_lvl({15'h0, tx_valid}, 16'h0000);
    chk_lvl(16'(q.size()), 16'h0001);
    delim1_en <= 1'b1;
    pk(8'h0d, 1, 1);
    drain;
    delim1_en <= 1'b0;
    for (p = 0; p < 2; p++) begin
      pkt_len <= p ? 11'h400 : 11'h000;
      for (i = 0; i < 1024; i++) pk(8'($urandom), 1, i == 1023);
      drain;
    end
    max_conn <= 4'h4;
    ignore_jammed <= 1'b1;
    host_active <= 8'h0f;
    pkt_len <= 11'h004;
    for (i = 0; i < 4; i++) pk(8'($urandom), 1, i == 3);
    drain;
    chk_lvl(ser_cfg, local_cfg);
    cmd(1, 0, 1, 0, 2'b11);
    allow_drv_ctrl <= 1'b1;
    cmd(0, 0, 1, 0, 2'b10);
    max_conn <= 4'h1;
    cmd(1, 1, 0, 1, 2'b01);
    net_up <= 1'b0;
    cmd(1, 1, 1, 1, 2'b11);
    conn_down_low <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk_lvl({14'h0, rts_out, dtr_out}, 16'h0000);
    give_verdict;
  end
endmodule // sdpf_framer_tb
